/* File: clock_timer_map.svh */
// Purpose: offsets, field positions, reset values and counts of the clock and basic timer block
// Assumes: 8-bit register file port, byte addresses
// Notes: definitions only
`ifndef CLOCK_TIMER_MAP_SVH
`define CLOCK_TIMER_MAP_SVH

`define BT_CTRL_ADDR       8'hD3
`define CPU_DIV_CTRL_ADDR  8'hD4
`define OSC_CTRL_ADDR      8'hFB
`define BT_COUNT_ADDR      8'hFD

`define BT_CTRL_RESET      8'h00
`define CPU_DIV_RESET      8'h00
`define OSC_CTRL_RESET     8'h00

`define BT_WDOG_OFF_CODE   4'hA
`define BT_CNT_CLR_BIT     1
`define BT_PRE_CLR_BIT     0
`define CPU_DIV_MASK       8'h18
`define OSC_CTRL_MASK      8'h1D

`define PRESCALE_WIDTH     12
`define DIV_TAP_4096       11
`define DIV_TAP_1024       9
`define DIV_TAP_128        6
`define DIV_TAP_16         3
`define DIV_TAP_8          2
`define DIV_TAP_2          0

`endif

/* File: clock_timer_pkg.sv */
// Purpose: types of the clock and basic timer block
// Assumes: nothing
// Notes: field layouts follow the register map
package clock_timer_pkg;

    typedef enum logic [1:0] {
        CPU_DIV16,
        CPU_DIV8,
        CPU_DIV2,
        CPU_DIV1
    } cpu_div_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] wdogCode;
        logic [1:0] btClkSel;
    } bt_ctrl_t;

    typedef struct packed {
        logic strongDriveOff;
        logic mainStop;
        logic subStop;
        logic subSelect;
    } osc_ctrl_t;

endpackage

/* File: clock_prescaler.sv */
// Purpose: free running divider chain on the base clock
// Assumes: clear is a one-cycle pulse
// Notes: bit n toggles at base/2^(n+1)
`timescale 1ns/100ps
module clock_prescaler #(
    parameter int WIDTH = 12
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    always_comb begin
        count_next = clear ? '0 : count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule // clock_prescaler

/* File: clock_timer_ctrl.sv */
// Purpose: clock source select, CPU divider, oscillator control, basic timer, watchdog gate
// Assumes: core_clk is the selected oscillator clock; register port is register addressing only
// Notes: registered read data, one cycle after the address
`timescale 1ns/100ps
`include "clock_timer_map.svh"
module clock_timer_ctrl (
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire clock_timer_pkg::reg_req_t   regReq,
    output logic                       [7:0] regRdata,
    output logic                             subClkSelect,
    output logic                             mainOscStop,
    output logic                             subOscStop,
    output logic                             subDriveNormal,
    output logic                             cpuClkTick,
    output logic                             watchdogEnable,
    output logic                       [7:0] btCount,
    output logic                             btOverflow
);
    typedef struct packed {
        clock_timer_pkg::bt_ctrl_t  bt;
        clock_timer_pkg::cpu_div_t  cpuDiv;
        clock_timer_pkg::osc_ctrl_t osc;
        logic [7:0]                 btCnt;
        logic                       btTapLast;
        logic                       cpuTapLast;
        logic                       btTick;
        logic                       cpuTick;
        logic                       btOvf;
        logic                       wdogEn;
        logic [7:0]                 rdata;
    } state_t;

    state_t                          state_reg;
    state_t                          state_next;
    logic [`PRESCALE_WIDTH-1:0]      prescale;
    logic                            preClear;
    logic                            btTap;
    logic                            cpuTap;
    logic                            btWr;

    assign btWr     = regReq.write && regReq.addr == `BT_CTRL_ADDR;
    assign preClear = btWr && regReq.wdata[`BT_PRE_CLR_BIT];

    // Base clock is core_clk, already the selected oscillator
    clock_prescaler #(.WIDTH(`PRESCALE_WIDTH)) prescaler_u (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clear    (preClear),
        .count    (prescale)
    );

    always_comb begin
        case (state_reg.bt.btClkSel)
            2'b00:   btTap = prescale[`DIV_TAP_4096];
            2'b01:   btTap = prescale[`DIV_TAP_1024];
            2'b10:   btTap = prescale[`DIV_TAP_128];
            default: btTap = 1'b0;
        endcase
        case (state_reg.cpuDiv)
            clock_timer_pkg::CPU_DIV16: cpuTap = prescale[`DIV_TAP_16];
            clock_timer_pkg::CPU_DIV8:  cpuTap = prescale[`DIV_TAP_8];
            clock_timer_pkg::CPU_DIV2:  cpuTap = prescale[`DIV_TAP_2];
            default:                    cpuTap = ~state_reg.cpuTapLast;
        endcase
    end

    always_comb begin
        state_next            = state_reg;
        state_next.btTapLast  = preClear ? 1'b0 : btTap;
        state_next.cpuTapLast = preClear ? 1'b0 : cpuTap;
        state_next.btTick     = btTap && !state_reg.btTapLast && !preClear;
        state_next.cpuTick    = (state_reg.cpuDiv == clock_timer_pkg::CPU_DIV1)
                                || (cpuTap && !state_reg.cpuTapLast);
        state_next.btOvf      = 1'b0;
        if (state_reg.btTick) begin
            state_next.btCnt = state_reg.btCnt + 8'h01;
            state_next.btOvf = state_reg.btCnt == 8'hFF;
        end
        if (regReq.write) begin
            case (regReq.addr)
                `BT_CTRL_ADDR: begin
                    state_next.bt.wdogCode = regReq.wdata[7:4];
                    state_next.bt.btClkSel = regReq.wdata[3:2];
                    if (regReq.wdata[`BT_CNT_CLR_BIT]) begin
                        state_next.btCnt = 8'h00;
                        state_next.btOvf = 1'b0;
                    end
                end
                `CPU_DIV_CTRL_ADDR: begin
                    state_next.cpuDiv = clock_timer_pkg::cpu_div_t'(regReq.wdata[4:3]);
                end
                `OSC_CTRL_ADDR: begin
                    state_next.osc.strongDriveOff = regReq.wdata[4];
                    state_next.osc.mainStop       = regReq.wdata[3];
                    state_next.osc.subStop        = regReq.wdata[2];
                    state_next.osc.subSelect      = regReq.wdata[0];
                end
                default: ;
            endcase
        end
        // Enable kept in a flop so the output needs no gate
        state_next.wdogEn = state_next.bt.wdogCode != `BT_WDOG_OFF_CODE;
        // Clear bits read back zero: they are not stored, they act only in the cycle of the write
        case (regReq.addr)
            `BT_CTRL_ADDR:      state_next.rdata = {state_reg.bt.wdogCode,
                                                    state_reg.bt.btClkSel, 2'b00};
            `CPU_DIV_CTRL_ADDR: state_next.rdata = {3'b000, state_reg.cpuDiv, 3'b000};
            `OSC_CTRL_ADDR:     state_next.rdata = {3'b000, state_reg.osc.strongDriveOff,
                                                    state_reg.osc.mainStop,
                                                    state_reg.osc.subStop, 1'b0,
                                                    state_reg.osc.subSelect};
            `BT_COUNT_ADDR:     state_next.rdata = state_reg.btCnt;
            default:            state_next.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg        <= '0;
            state_reg.wdogEn <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdata       = state_reg.rdata;
    assign subClkSelect   = state_reg.osc.subSelect;
    assign mainOscStop    = state_reg.osc.mainStop;
    assign subOscStop     = state_reg.osc.subStop;
    assign subDriveNormal = state_reg.osc.strongDriveOff;
    assign cpuClkTick     = state_reg.cpuTick;
    assign watchdogEnable = state_reg.wdogEn;
    assign btCount        = state_reg.btCnt;
    assign btOverflow     = state_reg.btOvf;
endmodule // clock_timer_ctrl

/* File: clock_timer_ctrl_props.sv */
// Purpose: concurrent checks on the clock and basic timer control ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to the design by bind at the foot of this file
`timescale 1ns/100ps
module clock_timer_ctrl_props (
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire clock_timer_pkg::reg_req_t regReq,
    input wire logic                      subClkSelect,
    input wire logic                      mainOscStop,
    input wire logic                      subOscStop,
    input wire logic                      subDriveNormal,
    input wire logic                      watchdogEnable,
    input wire logic [7:0]                btCount
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_timer_wr;
        regReq.write && regReq.addr == 8'hD3;
    endsequence
    sequence s_osc_wr;
        regReq.write && regReq.addr == 8'hFB;
    endsequence

    a_count_clear:
        assert property (s_timer_wr ##0 regReq.wdata[1] |=> btCount == 8'h00)
        else $error("timer count not zeroed after clear write");
    a_osc_select:
        assert property (s_osc_wr |=> subClkSelect == $past(regReq.wdata[0]))
        else $error("system clock select does not follow write");
    a_main_stop:
        assert property (s_osc_wr |=> mainOscStop == $past(regReq.wdata[3]))
        else $error("main oscillator stop does not follow write");
    a_sub_stop:
        assert property (s_osc_wr |=> subOscStop == $past(regReq.wdata[2]))
        else $error("sub oscillator stop does not follow write");
    a_drive_normal:
        assert property (s_osc_wr |=> subDriveNormal == $past(regReq.wdata[4]))
        else $error("sub drive strength does not follow write");
    a_wdog_off:
        assert property (s_timer_wr ##0 regReq.wdata[7:4] == 4'hA |=> !watchdogEnable)
        else $error("watchdog still enabled after disable code");
    a_wdog_on:
        assert property (s_timer_wr ##0 regReq.wdata[7:4] != 4'hA |=> watchdogEnable)
        else $error("watchdog disabled by other code");
    a_reset_state:
        assert property ($rose(rst_n) |-> watchdogEnable && btCount == 8'h00 && !subClkSelect)
        else $error("wrong state after reset");
    a_count_step:
        assert property (!$stable(btCount) |-> btCount == 8'h00 || btCount == $past(btCount) + 8'h01)
        else $error("timer count moved other than by one");
endmodule // clock_timer_ctrl_props

bind clock_timer_ctrl clock_timer_ctrl_props u_props (.core_clk(core_clk), .rst_n(rst_n),
    .regReq(regReq), .subClkSelect(subClkSelect), .mainOscStop(mainOscStop),
    .subOscStop(subOscStop), .subDriveNormal(subDriveNormal),
    .watchdogEnable(watchdogEnable), .btCount(btCount));

/* File: clock_and_basic_timer_control_test.sv */
// Purpose: register-level tests of the clock and basic timer control block
// Assumes: inputs driven 1 ns after the rising edge
// Notes: read data is checked one cycle after the address is shown
`timescale 1ns/100ps
module clock_and_basic_timer_control_test;
    logic                      core_clk;
    logic                      rst_n;
    clock_timer_pkg::reg_req_t regReq;
    logic [7:0]                regRdata;
    logic [7:0]                btCount;
    logic                      subClkSelect, mainOscStop, subOscStop, subDriveNormal;
    logic                      cpuClkTick, watchdogEnable, btOverflow;
    logic [7:0]                gaps [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
    int                        fails = 0;
    int                        n_checks = 0;
    int                        cyc = 0;

    clock_timer_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
        .regRdata(regRdata), .subClkSelect(subClkSelect), .mainOscStop(mainOscStop),
        .subOscStop(subOscStop), .subDriveNormal(subDriveNormal), .cpuClkTick(cpuClkTick),
        .watchdogEnable(watchdogEnable), .btCount(btCount), .btOverflow(btOverflow));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        regReq.write = 1'b1;
        regReq.addr  = a;
        regReq.wdata = d;
        @(posedge core_clk);
        #1 regReq.write = 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] exp);
        regReq.read = 1'b1;
        regReq.addr = a;
        @(posedge core_clk);
        #1;
        chk("read data", exp, regRdata);
    endtask

    task automatic wait_cyc(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Third gap is measured so a period cut by a divider change is skipped
    task automatic tick_gap(logic [7:0] exp);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                wait_cyc(1);
                n++;
            end while (cpuClkTick !== 1'b1 && n < 40);
        end
        chk("tick gap", exp, 8'(n));
    endtask

    initial begin
        rst_n  = 1'b0;
        regReq = '0;
        wait_cyc(16);
        rst_n = 1'b1;
        rd(8'hD3, 8'h00);
        rd(8'hD4, 8'h00);
        rd(8'hFB, 8'h00);
        chk("watchdog enable", 8'h01, {7'h00, watchdogEnable});
        tick_gap(8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(8'hD4, 8'(i << 3));
            rd(8'hD4, 8'(i << 3));
            tick_gap(gaps[i]);
        end
        wr(8'hD4, 8'h18);
        rd(8'hD4, 8'h18);
        wr(8'hFB, 8'h1D);
        chk("osc outputs", 8'h0F, {4'h0, subDriveNormal, mainOscStop, subOscStop, subClkSelect});
        rd(8'hFB, 8'h1D);
        wr(8'hFB, 8'h08);
        chk("osc outputs", 8'h04, {4'h0, subDriveNormal, mainOscStop, subOscStop, subClkSelect});
        wr(8'hD3, 8'hA0);
        chk("watchdog enable", 8'h00, {7'h00, watchdogEnable});
        rd(8'hD3, 8'hA0);
        wr(8'hD3, 8'h50);
        chk("watchdog enable", 8'h01, {7'h00, watchdogEnable});
        wr(8'hD3, 8'h08);
        wait_cyc(300);
        chk("count running", 8'h01, {7'h00, btCount >= 8'h02});
        wr(8'hD3, 8'h0A);
        chk("count cleared", 8'h00, btCount);
        rd(8'hD3, 8'h08);
        wr(8'hD3, 8'h0B);
        wait_cyc(60);
        chk("count after divider clear", 8'h00, btCount);
        wait_cyc(80);
        chk("count after divider clear", 8'h01, btCount);
        rd(8'hFD, 8'h01);
        rd(8'hD3, 8'h08);
        rd(8'hFE, 8'h00);
        test_done();
    end
endmodule // clock_and_basic_timer_control_test
